// ---- inc/margin_fault_pkg.sv ----
// constants for the fault output and trim bank selection block
package margin_fault_pkg;
	localparam int N_CH = 12;
	localparam int N_PIN = 6;
	localparam int DAC_W = 8;
	localparam int MEM_DEPTH = 36;
	localparam int MEM_AW = 6;
	localparam int IDX_W = 8;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_BANK_NORM_LO = 8'h00;
	localparam logic [7:0] IDX_BANK_NORM_HI = 8'h0b;
	localparam logic [7:0] IDX_BANK_UP_LO = 8'h66;
	localparam logic [7:0] IDX_BANK_UP_HI = 8'h71;
	localparam logic [7:0] IDX_BANK_DN_LO = 8'h72;
	localparam logic [7:0] IDX_BANK_DN_HI = 8'h7d;
	localparam logic [7:0] IDX_FA_MASK_LO = 8'h15;
	localparam logic [7:0] IDX_FA_CFG = 8'h16;
	localparam logic [7:0] IDX_FB_MASK_LO = 8'h17;
	localparam logic [7:0] IDX_FB_CFG = 8'h18;
	localparam logic [7:0] IDX_PIN_MODE = 8'h1c;
	localparam logic [7:0] IDX_SW_EN = 8'h40;
	localparam logic [7:0] IDX_CTRL = 8'h4d;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h51;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h52;
	localparam logic [7:0] IDX_STATE = 8'h53;
	// memory base of each trim bank
	localparam logic [5:0] MEM_BASE_NORM = 6'h00;
	localparam logic [5:0] MEM_BASE_UP = 6'h0c;
	localparam logic [5:0] MEM_BASE_DN = 6'h18;
	// fault config fields
	localparam int CFG_OV_BIT = 4;
	localparam int CFG_UV_BIT = 5;
	localparam int CFG_EW_BIT = 6;
	localparam int CFG_POL_BIT = 7;
	localparam int CTRL_SOFT_MARGIN_BIT = 1;
	// reset values
	localparam logic [7:0] RST_FAULT_CFG = 8'h00;
	localparam logic [17:0] RST_PIN_MODE = 18'h00000;
	localparam logic [11:0] RST_SW_EN = 12'h000;
	localparam logic [7:0] RST_CTRL = 8'h00;
	// pin modes, 3 bits per pin
	localparam logic [2:0] MODE_PP_FAULT = 3'h3;
	localparam logic [2:0] MODE_OD_FAULT = 3'h4;
	localparam logic [2:0] MODE_SPECIAL = 3'h7;
	// interrupt status bits
	localparam int IRQ_W = 5;
	localparam int IRQ_ANY = 0;
	localparam int IRQ_FA = 1;
	localparam int IRQ_FB = 2;
	localparam int IRQ_PU = 3;
	localparam int IRQ_MARGIN = 4;
	typedef enum logic [1:0] {BANK_NORM, BANK_UP, BANK_DN} bank_type;
endpackage

// ---- hw/trim_bank_mem.sv ----
// trim value memory, one write port and two registered read ports
`timescale 1ns/1ps
module trim_bank_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 36,
	parameter int AW = 6
) (
	// clock
	input wire logic i_ref_clk,
	// write port
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_data,
	// read ports
	input wire logic [AW-1:0] i_rd_addr_a,
	output logic [WIDTH-1:0] o_rd_data_a,
	input wire logic [AW-1:0] i_rd_addr_b,
	output logic [WIDTH-1:0] o_rd_data_b
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge i_ref_clk) begin
		if (i_wr_en)
			mem[i_wr_addr] <= i_wr_data;
		o_rd_data_a <= mem[i_rd_addr_a];
		o_rd_data_b <= mem[i_rd_addr_b];
	end
endmodule // trim_bank_mem

// ---- hw/fault_output_margin_select.sv ----
// fault output drive and trim bank selection with avalon register slave
// Notes on behaviour
// - pins 1-4 in fault mode drive low on any ov, uv or ew flag.
// - pin 5 carries fault output a, pin 6 fault output b.
// - fault a channel mask is twelve bits over two registers.
// - fault a enables overvoltage, undervoltage and early warning by bits 4-6.
// - fault a polarity bit 7, zero active low, one active high.
// - fault b channel mask is twelve bits over its two registers.
// - fault b enables overvoltage, undervoltage and early warning by bits 4-6.
// - fault b polarity bit 7, zero active low, one active high.
// - a fault output asserts when any selected channel violates an enabled type.
// - pin 6 in power-up fault mode signals sequencing faults.
// - a power-up fault pulls all supply enables low and requests a log save.
// - pins 2 and 3 are active-low raise and lower margin inputs.
// - raise alone selects the upper trim bank and closes the switches.
// - lower alone selects the lower trim bank and closes the switches.
// - equal inputs select the normal bank; switches follow their enable bits.
// - one margin input alone closes the switches and enables margining.
// - while margining, fault outputs freeze and no faults are logged.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module fault_output_margin_select
	import margin_fault_pkg::*;
#(
	parameter int CHANNELS = margin_fault_pkg::N_CH
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// avalon-mm slave
	input wire logic [9:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// comparator flags and sequencer fault
	input wire logic [CHANNELS-1:0] i_ov_flag,
	input wire logic [CHANNELS-1:0] i_uv_flag,
	input wire logic [CHANNELS-1:0] i_ew_flag,
	input wire logic i_seq_fault,
	// general purpose pins
	input wire logic [margin_fault_pkg::N_PIN-1:0] i_pin_in,
	output logic [margin_fault_pkg::N_PIN-1:0] o_pin_out,
	output logic [margin_fault_pkg::N_PIN-1:0] o_pin_oe_n,
	// supply and logger control
	output logic o_supply_en_kill,
	output logic o_log_save_req,
	output logic o_margin_active,
	// trim outputs
	output logic [CHANNELS*margin_fault_pkg::DAC_W-1:0] o_trim_dac_out,
	output logic [CHANNELS-1:0] o_trim_switch_close,
	// interrupt
	output logic o_irq
);
	import margin_fault_pkg::*;

	// configuration registers
	logic [7:0] fa_mask_lo_r;
	logic [7:0] fa_cfg_r;
	logic [7:0] fb_mask_lo_r;
	logic [7:0] fb_cfg_r;
	logic [7:0] ctrl_r;
	logic [17:0] pin_mode_r;
	logic [11:0] sw_en_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_en_r;
	// bus handshake
	logic busy_r;
	logic wait_r;
	logic [31:0] rdata_r;
	// pin synchroniser
	logic [N_PIN-1:0] pin_s1_r;
	logic [N_PIN-1:0] pin_s2_r;
	// fault state
	logic any_r;
	logic fa_r;
	logic fb_r;
	logic pu_r;
	logic margin_r;
	logic [N_PIN-1:0] pin_out_r;
	logic [N_PIN-1:0] pin_oe_n_r;
	logic kill_r;
	logic save_r;
	logic irq_r;
	// trim scan
	logic [3:0] scan_ch_r;
	logic [3:0] scan_ch_d_r;
	logic [DAC_W-1:0] dac_r [CHANNELS];
	logic [CHANNELS-1:0] sw_close_r;

	// bus decode
	wire [7:0] idx = i_address[9:2];
	wire req = i_read | i_write;
	wire wr_fire = i_write & ~wait_r;
	wire [31:0] be_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
		{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
	wire wr_lane0 = wr_fire & i_byteenable[0];
	wire in_norm = idx <= IDX_BANK_NORM_HI;
	wire in_up = (idx >= IDX_BANK_UP_LO) & (idx <= IDX_BANK_UP_HI);
	wire in_dn = (idx >= IDX_BANK_DN_LO) & (idx <= IDX_BANK_DN_HI);
	wire in_mem = in_norm | in_up | in_dn;
	wire [5:0] mem_bus_addr = in_up ? MEM_BASE_UP + 6'(idx - IDX_BANK_UP_LO) :
		in_dn ? MEM_BASE_DN + 6'(idx - IDX_BANK_DN_LO) : 6'(idx);
	wire [DAC_W-1:0] mem_rd_a;
	wire [DAC_W-1:0] mem_rd_b;
	wire [31:0] merged_pin_mode = ({14'h0000, pin_mode_r} & ~be_mask) |
		(i_writedata & be_mask);
	wire [31:0] merged_sw_en = ({20'h00000, sw_en_r} & ~be_mask) |
		(i_writedata & be_mask);
	wire [IRQ_W-1:0] irq_clear = (wr_lane0 & (idx == IDX_IRQ_CLEAR)) ?
		i_writedata[IRQ_W-1:0] : '0;
	// register write strobes
	wire wr_fa_mask = wr_lane0 & (idx == IDX_FA_MASK_LO);
	wire wr_fa_cfg = wr_lane0 & (idx == IDX_FA_CFG);
	wire wr_fb_mask = wr_lane0 & (idx == IDX_FB_MASK_LO);
	wire wr_fb_cfg = wr_lane0 & (idx == IDX_FB_CFG);
	wire wr_pin_mode = wr_fire & (idx == IDX_PIN_MODE);
	wire wr_sw_en = wr_fire & (idx == IDX_SW_EN);
	wire wr_ctrl = wr_lane0 & (idx == IDX_CTRL);
	wire wr_irq_en = wr_lane0 & (idx == IDX_IRQ_ENABLE);

	// margin input decode, synchronised copies only
	wire [2:0] mode2 = pin_mode_r[5:3];
	wire [2:0] mode3 = pin_mode_r[8:6];
	wire raise_n = (mode2 == MODE_SPECIAL) ? pin_s2_r[1] : 1'b1;
	wire lower_n = (mode3 == MODE_SPECIAL) ? pin_s2_r[2] : 1'b1;
	wire raise_only = ~raise_n & lower_n;
	wire lower_only = raise_n & ~lower_n;
	bank_type bank_sel;
	assign bank_sel = raise_only ? BANK_UP : lower_only ? BANK_DN : BANK_NORM;
	wire [5:0] bank_base = (bank_sel == BANK_UP) ? MEM_BASE_UP :
		(bank_sel == BANK_DN) ? MEM_BASE_DN : MEM_BASE_NORM;
	wire margin_nxt = raise_only | lower_only | ctrl_r[CTRL_SOFT_MARGIN_BIT];
	wire [CHANNELS-1:0] sw_close_nxt = (raise_only | lower_only) ?
		{CHANNELS{1'b1}} : sw_en_r[CHANNELS-1:0];

	// fault combination
	wire [CHANNELS-1:0] fa_mask = {fa_cfg_r[3:0], fa_mask_lo_r};
	wire [CHANNELS-1:0] fb_mask = {fb_cfg_r[3:0], fb_mask_lo_r};
	wire [CHANNELS-1:0] fa_viol = (i_ov_flag & {CHANNELS{fa_cfg_r[CFG_OV_BIT]}}) |
		(i_uv_flag & {CHANNELS{fa_cfg_r[CFG_UV_BIT]}}) |
		(i_ew_flag & {CHANNELS{fa_cfg_r[CFG_EW_BIT]}});
	wire [CHANNELS-1:0] fb_viol = (i_ov_flag & {CHANNELS{fb_cfg_r[CFG_OV_BIT]}}) |
		(i_uv_flag & {CHANNELS{fb_cfg_r[CFG_UV_BIT]}}) |
		(i_ew_flag & {CHANNELS{fb_cfg_r[CFG_EW_BIT]}});
	wire any_raw = |(i_ov_flag | i_uv_flag | i_ew_flag);
	wire fa_raw = |(fa_mask & fa_viol);
	wire fb_raw = |(fb_mask & fb_viol);
	// frozen while margining
	wire any_nxt = margin_r ? any_r : any_raw;
	wire fa_nxt = margin_r ? fa_r : fa_raw;
	wire fb_nxt = margin_r ? fb_r : fb_raw;
	wire pu_mode = pin_mode_r[17:15] == MODE_SPECIAL;
	// a clear landing with a new fault lets the fault win
	wire pu_event = i_seq_fault & pu_mode & ~margin_r & (~pu_r | irq_clear[IRQ_PU]);
	wire pu_nxt = pu_event | (pu_r & ~irq_clear[IRQ_PU]);

	// polarity applied after combining
	wire any_level = ~any_r;
	wire fa_level = ~(fa_r ^ fa_cfg_r[CFG_POL_BIT]);
	wire fb_level = ~(fb_r ^ fb_cfg_r[CFG_POL_BIT]);

	// per pin drive
	// a released pin keeps oe_n high and out low
	logic [N_PIN-1:0] pin_out_nxt;
	logic [N_PIN-1:0] pin_oe_n_nxt;
	genvar gp;
	generate
		for (gp = 0; gp < N_PIN; gp++) begin : g_pin
			wire [2:0] mode = pin_mode_r[3*gp+2:3*gp];
			wire pu_sel = (gp == N_PIN - 1) && (mode == MODE_SPECIAL);
			wire pp = mode == MODE_PP_FAULT;
			wire od = (mode == MODE_OD_FAULT) | pu_sel;
			wire level = pu_sel ? ~pu_r : (gp == 4) ? fa_level :
				(gp == 5) ? fb_level : any_level;
			assign pin_out_nxt[gp] = pp ? level : 1'b0;
			assign pin_oe_n_nxt[gp] = pp ? 1'b0 : od ? level : 1'b1;
		end
	endgenerate

	// interrupt events
	wire any_rise = any_nxt & ~any_r;
	wire fa_rise = fa_nxt & ~fa_r;
	wire fb_rise = fb_nxt & ~fb_r;
	wire margin_change = margin_nxt ^ margin_r;
	wire [IRQ_W-1:0] irq_ev = {margin_change, pu_event, fb_rise, fa_rise, any_rise};
	wire [IRQ_W-1:0] irq_stat_nxt = irq_ev | (irq_stat_r & ~irq_clear);
	wire irq_nxt = |(irq_stat_nxt & irq_en_r);

	// read mux
	wire [31:0] state_word = {25'h0000000, 2'(bank_sel), margin_r, pu_r, fb_r, fa_r, any_r};
	wire [31:0] rd_mux = in_mem ? {24'h000000, mem_rd_a} :
		(idx == IDX_FA_MASK_LO) ? {24'h000000, fa_mask_lo_r} :
		(idx == IDX_FA_CFG) ? {24'h000000, fa_cfg_r} :
		(idx == IDX_FB_MASK_LO) ? {24'h000000, fb_mask_lo_r} :
		(idx == IDX_FB_CFG) ? {24'h000000, fb_cfg_r} :
		(idx == IDX_PIN_MODE) ? {14'h0000, pin_mode_r} :
		(idx == IDX_SW_EN) ? {20'h00000, sw_en_r} :
		(idx == IDX_CTRL) ? {24'h000000, ctrl_r} :
		(idx == IDX_IRQ_STATUS) ? {27'h0000000, irq_stat_r} :
		(idx == IDX_IRQ_ENABLE) ? {27'h0000000, irq_en_r} :
		(idx == IDX_STATE) ? state_word : 32'h00000000;

	// bank memory has no reset; software fills the banks before use
	trim_bank_mem #(
		.WIDTH(DAC_W),
		.DEPTH(MEM_DEPTH),
		.AW(MEM_AW)
	) u_mem (
		.i_ref_clk(i_ref_clk),
		.i_wr_en(wr_lane0 & in_mem),
		.i_wr_addr(mem_bus_addr),
		.i_wr_data(i_writedata[DAC_W-1:0]),
		.i_rd_addr_a(mem_bus_addr),
		.o_rd_data_a(mem_rd_a),
		.i_rd_addr_b(bank_base + 6'(scan_ch_r)),
		.o_rd_data_b(mem_rd_b)
	);

	// bus handshake: taken, then data loaded as waitrequest goes low for one cycle
	// readdata loads at the edge that drops waitrequest, so both stand together
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			busy_r <= 1'b0;
			wait_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else if (!wait_r) begin
			busy_r <= 1'b0;
			wait_r <= 1'b1;
		end else if (req && busy_r) begin
			wait_r <= 1'b0;
			rdata_r <= i_read ? rd_mux : 32'h00000000;
		end else begin
			busy_r <= req;
		end
	end

	// configuration writes
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			fa_mask_lo_r <= RST_FAULT_CFG;
			fa_cfg_r <= RST_FAULT_CFG;
			fb_mask_lo_r <= RST_FAULT_CFG;
			fb_cfg_r <= RST_FAULT_CFG;
			pin_mode_r <= RST_PIN_MODE;
			sw_en_r <= RST_SW_EN;
			ctrl_r <= RST_CTRL;
			irq_en_r <= '0;
		end else begin
			if (wr_fa_mask)
				fa_mask_lo_r <= i_writedata[7:0];
			if (wr_fa_cfg)
				fa_cfg_r <= i_writedata[7:0];
			if (wr_fb_mask)
				fb_mask_lo_r <= i_writedata[7:0];
			if (wr_fb_cfg)
				fb_cfg_r <= i_writedata[7:0];
			if (wr_pin_mode)
				pin_mode_r <= merged_pin_mode[17:0];
			if (wr_sw_en)
				sw_en_r <= merged_sw_en[11:0];
			if (wr_ctrl)
				ctrl_r <= i_writedata[7:0];
			if (wr_irq_en)
				irq_en_r <= i_writedata[IRQ_W-1:0];
		end
	end

	// two-flop pin synchroniser
	// no reset: the chain flushes within the reset hold
	always_ff @(posedge i_ref_clk) begin
		pin_s1_r <= i_pin_in;
		pin_s2_r <= pin_s1_r;
	end

	// fault state and outputs
	// supply kill holds until software clears the latched fault
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			any_r <= 1'b0;
			fa_r <= 1'b0;
			fb_r <= 1'b0;
			pu_r <= 1'b0;
			margin_r <= 1'b0;
			pin_out_r <= '0;
			pin_oe_n_r <= '1;
			kill_r <= 1'b0;
			save_r <= 1'b0;
			irq_stat_r <= '0;
			irq_r <= 1'b0;
		end else begin
			any_r <= any_nxt;
			fa_r <= fa_nxt;
			fb_r <= fb_nxt;
			pu_r <= pu_nxt;
			margin_r <= margin_nxt;
			pin_out_r <= pin_out_nxt;
			pin_oe_n_r <= pin_oe_n_nxt;
			kill_r <= pu_nxt;
			save_r <= pu_event;
			irq_stat_r <= irq_stat_nxt;
			irq_r <= irq_nxt;
		end
	end

	// trim scan through the selected bank
	// each channel refreshes once per pass of the scan
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			scan_ch_r <= 4'h0;
			scan_ch_d_r <= 4'h0;
			sw_close_r <= '0;
		end else begin
			scan_ch_r <= (scan_ch_r == 4'(CHANNELS - 1)) ? 4'h0 : scan_ch_r + 4'h1;
			scan_ch_d_r <= scan_ch_r;
			sw_close_r <= sw_close_nxt;
		end
	end

	genvar gc;
	generate
		for (gc = 0; gc < CHANNELS; gc++) begin : g_dac
			always_ff @(posedge i_ref_clk) begin
				if (!i_resetn)
					dac_r[gc] <= '0;
				else if (scan_ch_d_r == 4'(gc))
					dac_r[gc] <= mem_rd_b;
			end
			assign o_trim_dac_out[gc*DAC_W +: DAC_W] = dac_r[gc];
		end
	endgenerate

	assign o_readdata = rdata_r;
	assign o_waitrequest = wait_r;
	assign o_pin_out = pin_out_r;
	assign o_pin_oe_n = pin_oe_n_r;
	assign o_supply_en_kill = kill_r;
	assign o_log_save_req = save_r;
	assign o_margin_active = margin_r;
	assign o_trim_switch_close = sw_close_r;
	assign o_irq = irq_r;
endmodule // fault_output_margin_select

// ---- verif/fault_margin_asserts.sv ----
// port assertions for the fault output and trim select block
`timescale 1ns/1ps
module fault_margin_asserts
	import margin_fault_pkg::*;
#(
	parameter int CHANNELS = N_CH
) (
	// clock, reset and bus
	input logic i_ref_clk,
	input logic i_resetn,
	input logic i_read,
	input logic i_write,
	input logic [9:0] i_address,
	input logic [3:0] i_byteenable,
	input logic [31:0] i_writedata,
	input logic [31:0] o_readdata,
	input logic o_waitrequest,
	// faults, pins, margin
	input logic i_seq_fault,
	input logic [N_PIN-1:0] i_pin_in,
	input logic [N_PIN-1:0] o_pin_out,
	input logic [N_PIN-1:0] o_pin_oe_n,
	input logic o_supply_en_kill,
	input logic o_log_save_req,
	input logic o_margin_active,
	input logic [CHANNELS-1:0] o_trim_switch_close
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	logic req;
	logic [2:0] quiet_r;
	logic [2:0] quiet_nxt;
	// cycles of margining with no register write
	assign req = i_read | i_write;
	assign quiet_nxt = (!o_margin_active || i_write) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
	always_ff @(posedge i_ref_clk) begin
		quiet_r <= i_resetn ? quiet_nxt : 3'h0;
	end
	// software margin enable as last written
	logic soft_r;
	logic all_closed;
	assign all_closed = &o_trim_switch_close;
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn)
			soft_r <= 1'b0;
		else if (i_write && !o_waitrequest && i_byteenable[0] && i_address[9:2] == IDX_CTRL)
			soft_r <= i_writedata[CTRL_SOFT_MARGIN_BIT];
	end
	sequence s_req_start;
		req && o_waitrequest && (!$past(req) || !$past(o_waitrequest));
	endsequence
	sequence s_one_low;
		(i_pin_in[1] ^ i_pin_in[2]) [*4];
	endsequence
	sequence s_both_same;
		(i_pin_in[1] == i_pin_in[2] && !soft_r) [*4];
	endsequence
	chk_wait_two: assert property (s_req_start |-> ##1 o_waitrequest ##1 !o_waitrequest)
		else $error("late or early waitrequest");
	chk_wait_single: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest low too long");
	chk_write_zero: assert property (i_write && !o_waitrequest |-> o_readdata == 32'h0)
		else $error("readdata not zero on write");
	chk_margin_close: assert property (s_one_low |=> o_margin_active && all_closed)
		else $error("margin input did not close switches");
	chk_soft_margin: assert property (soft_r |=> o_margin_active)
		else $error("software margin enable not applied");
	chk_margin_off: assert property (s_both_same |=> !o_margin_active)
		else $error("margin active with equal inputs");
	chk_fault_freeze: assert property (
		quiet_r == 3'h7 |-> $stable(o_pin_out) && $stable(o_pin_oe_n))
		else $error("fault pins moved while margining");
	chk_kill_save: assert property ($rose(o_supply_en_kill) |-> o_log_save_req)
		else $error("no log save with supply kill");
	chk_kill_cause: assert property (
		$rose(o_supply_en_kill) |-> $past(i_seq_fault) && !$past(o_margin_active))
		else $error("supply kill without sequencing fault");
	chk_save_pulse: assert property (o_log_save_req |=> !o_log_save_req)
		else $error("log save longer than one cycle");
endmodule // fault_margin_asserts

bind fault_output_margin_select fault_margin_asserts #(.CHANNELS(CHANNELS)) u_chk (.*);

// ---- verif/margin_host_model.sv ----
// far-side margin controller with pin pull-ups
`timescale 1ns/1ps
module margin_host_model (
	// clock and command
	input logic i_ref_clk,
	input logic [1:0] i_cmd,
	// device pin drive and resolved levels
	input logic [5:0] i_dut_out,
	input logic [5:0] i_dut_oe_n,
	output logic [5:0] o_pin
);
	logic raise_n_r = 1'b1;
	logic lower_n_r = 1'b1;
	logic [5:0] pulled;
	// released pins go to the pull-up level
	assign pulled = i_dut_oe_n | i_dut_out;
	assign o_pin = {pulled[5:3], lower_n_r, raise_n_r, pulled[0]};
	always @(posedge i_ref_clk) begin
		raise_n_r <= !i_cmd[0];
		lower_n_r <= !i_cmd[1];
	end
endmodule // margin_host_model

// ---- verif/tb_top.sv ----
// self-checking bench for the fault output and trim select block
`timescale 1ns/1ps
module tb_top;
	import margin_fault_pkg::*;
	logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_read = 1'b0, i_write = 1'b0, i_seq_fault = 1'b0;
	logic [9:0] i_address = 10'h000;
	logic [3:0] i_byteenable = 4'hf;
	logic [31:0] i_writedata = 32'h0, o_readdata, q;
	logic [N_CH-1:0] i_ov_flag = '0, i_uv_flag = '0, i_ew_flag = '0, o_trim_switch_close;
	logic [N_PIN-1:0] i_pin_in, o_pin_out, o_pin_oe_n;
	logic o_waitrequest, o_supply_en_kill, o_log_save_req, o_margin_active, o_irq;
	logic [N_CH*DAC_W-1:0] o_trim_dac_out, exp_dac;
	logic [1:0] margin_cmd = 2'h0;
	int mismatches = 0, check_count = 0, cycles = 0, saves = 0;
	always #2 i_ref_clk = ~i_ref_clk;
	fault_output_margin_select dut (.*);
	margin_host_model host (.i_ref_clk(i_ref_clk), .i_cmd(margin_cmd), .i_dut_out(o_pin_out),
		.i_dut_oe_n(o_pin_oe_n), .o_pin(i_pin_in));
	always @(posedge i_ref_clk) begin
		cycles++;
		if (o_log_save_req === 1'b1)
			saves++;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [95:0] g, input logic [95:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_address <= {idx, 2'b00};
		i_writedata <= d;
		i_write <= w;
		i_read <= !w;
		do
			@(posedge i_ref_clk);
		while (o_waitrequest !== 1'b0);
		q = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 32'h0);
		chk(q, e);
	endtask
	task automatic seq_pulse();
		@(posedge i_ref_clk);
		i_seq_fault <= 1'b1;
		@(posedge i_ref_clk);
		i_seq_fault <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
	endtask
	// e is {pin6 out, pin5 out, pin4 out, pin1 oe_n}
	task automatic fcase(input int t, input int ch, input logic [3:0] e);
		logic [N_CH-1:0] m;
		m = '0;
		m[ch] = (t != 3);
		@(posedge i_ref_clk);
		i_ov_flag <= (t == 0) ? m : '0;
		i_uv_flag <= (t == 1) ? m : '0;
		i_ew_flag <= (t == 2) ? m : '0;
		repeat (4) @(posedge i_ref_clk);
		chk({o_pin_out[5:3], o_pin_oe_n[0], o_pin_oe_n[4], o_pin_out[0]}, {e, 2'b00});
	endtask
	task automatic mcase(input logic [1:0] c, input logic [7:0] base, input logic [11:0] sw,
		input logic act, input bank_type bk);
		@(posedge i_ref_clk);
		margin_cmd <= c;
		repeat (20) @(posedge i_ref_clk);
		for (int g = 0; g < N_CH; g++)
			exp_dac[g*8 +: 8] = base + 8'(g);
		chk(o_trim_dac_out, exp_dac);
		chk({o_margin_active, o_trim_switch_close}, {act, sw});
		bus(1'b0, IDX_STATE, 32'h0);
		chk(q & 32'h70, {25'h0, 2'(bk), act, 4'h0});
	endtask
	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			rdchk(IDX_FA_MASK_LO + 8'(k), 32'h0);
			bus(1'b1, IDX_FA_MASK_LO + 8'(k), 32'hffff_ff50 + k);
			rdchk(IDX_FA_MASK_LO + 8'(k), 32'h50 + k);
		end
		bus(1'b1, 8'h30, 32'h5);
		rdchk(8'h30, 32'h0);
		rdchk(IDX_IRQ_CLEAR, 32'h0);
		bus(1'b1, IDX_PIN_MODE, 32'h1b7fc);
		bus(1'b1, IDX_FA_MASK_LO, 32'h0);
		bus(1'b1, IDX_FA_CFG, 32'h12);
		bus(1'b1, IDX_FB_MASK_LO, 32'h4);
		bus(1'b1, IDX_FB_CFG, 32'hc0);
		fcase(0, 9, 4'h0);
		fcase(1, 9, 4'h4);
		fcase(0, 8, 4'h4);
		fcase(2, 2, 4'hc);
		fcase(0, 2, 4'h4);
		fcase(3, 0, 4'h7);
		bus(1'b1, IDX_FA_CFG, 32'h92);
		fcase(0, 9, 4'h4);
		bus(1'b1, IDX_PIN_MODE, 32'h3b7fc);
		bus(1'b1, IDX_IRQ_ENABLE, 32'h8);
		seq_pulse();
		chk({o_supply_en_kill, o_irq, o_pin_oe_n[5], o_pin_out[5], saves == 1}, 5'b11001);
		bus(1'b0, IDX_IRQ_STATUS, 32'h0);
		chk(q & 32'h8, 32'h8);
		bus(1'b1, IDX_IRQ_ENABLE, 32'h0);
		repeat (2) @(posedge i_ref_clk);
		chk(o_irq, 1'b0);
		bus(1'b1, IDX_IRQ_CLEAR, 32'h8);
		bus(1'b1, IDX_IRQ_ENABLE, 32'h8);
		repeat (2) @(posedge i_ref_clk);
		chk({o_supply_en_kill, o_irq, o_pin_oe_n[5]}, 3'b001);
		rdchk(IDX_IRQ_STATUS, 32'h7);
		for (int g = 0; g < N_CH; g++) begin
			bus(1'b1, IDX_BANK_NORM_LO + 8'(g), 32'h10 + g);
			bus(1'b1, IDX_BANK_UP_LO + 8'(g), 32'h40 + g);
			bus(1'b1, IDX_BANK_DN_LO + 8'(g), 32'h80 + g);
		end
		bus(1'b1, IDX_SW_EN, 32'habc);
		mcase(2'h0, 8'h10, 12'habc, 1'b0, BANK_NORM);
		mcase(2'h1, 8'h40, 12'hfff, 1'b1, BANK_UP);
		fcase(3, 0, 4'h4);
		seq_pulse();
		chk({o_supply_en_kill, saves == 1}, 2'b01);
		mcase(2'h2, 8'h80, 12'hfff, 1'b1, BANK_DN);
		mcase(2'h3, 8'h10, 12'habc, 1'b0, BANK_NORM);
		bus(1'b1, IDX_CTRL, 32'h2);
		repeat (2) @(posedge i_ref_clk);
		chk({o_margin_active, o_trim_switch_close}, {1'b1, 12'habc});
		bus(1'b1, IDX_CTRL, 32'h0);
		end_sim();
	end
endmodule // tb_top
